//--- speculative_load_tracking_table.sv
// speculative load tracking table with check, recovery and load latency
// assumes the issue pipeline presents one op per cycle, in program order
`timescale 1ns/100ps
module speculative_load_tracking_table #(
  parameter int Entries = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // issue side
  input wire logic reqValid,
  input wire sltt_pkg::req_s req,
  input wire logic [sltt_pkg::AddrW-1:0] pc,
  output logic reqReady,
  // load completion from memory
  input wire logic loadFault,
  input wire logic [sltt_pkg::DataW-1:0] memData,
  // stores in program order within the group
  input wire logic storeValid,
  input wire sltt_pkg::store_s store,
  input wire logic [sltt_pkg::DataW-1:0] storeData,
  // consumer stall query
  input wire logic [sltt_pkg::RegW-1:0] useReg,
  input wire logic useValid,
  output logic useStall,
  // memory request
  output logic memRd,
  output logic [sltt_pkg::AddrW-1:0] memRdAddr,
  output logic memWr,
  output logic [sltt_pkg::AddrW-1:0] memWrAddr,
  output logic [sltt_pkg::DataW-1:0] memWrData,
  // results
  output logic checkDone,
  output logic checkHit,
  output logic redirect,
  output logic [sltt_pkg::AddrW-1:0] redirectPc,
  output logic wbValid,
  output logic [sltt_pkg::RegW-1:0] wbReg,
  output logic [sltt_pkg::DataW-1:0] wbData,
  output logic wbDeferred
);
  localparam int PtrW = $clog2(Entries);

  ////////////////////////////////////////////////////////////////////////
  // entry array
  logic [Entries-1:0] entValid;
  logic [Entries-1:0] entRegMatch;
  logic [Entries-1:0] entHit;
  logic [Entries-1:0] entAlloc;
  logic [Entries-1:0] entKill;
  logic [PtrW-1:0] victim_q;
  logic [PtrW-1:0] target;
  logic sameFound;
  logic freeFound;
  logic [PtrW-1:0] samePtr;
  logic [PtrW-1:0] freePtr;
  logic isAdv;
  logic isCheck;
  logic doAlloc;
  logic anyHit;
  logic pipeBusy;
  logic pipeDone;
  logic [sltt_pkg::RegW-1:0] pipeReg;
  logic start;

  genvar gi;
  generate
    for (gi = 0; gi < Entries; gi++) begin : gEnt
      sltt_entry uEnt (
        .clk(clk),
        .nrst(nrst),
        .alloc(entAlloc[gi]),
        .kill(entKill[gi]),
        .fill(req),
        .probeReg(req.reg_),
        .probeFloat(req.isFloat),
        .store(store),
        .storeValid(storeValid),
        .valid(entValid[gi]),
        .regMatch(entRegMatch[gi]),
        .hit(entHit[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // operation decode; only one load in flight keeps ordering simple
  assign reqReady = !pipeBusy;
  assign isAdv = reqValid && reqReady &&
                 ((req.op == sltt_pkg::OpAdvLoad) ||
                  (req.op == sltt_pkg::OpSpecAdvLoad));
  assign isCheck = reqValid && reqReady &&
                   ((req.op == sltt_pkg::OpCheckLoad) ||
                    (req.op == sltt_pkg::OpCheckBranch));
  assign anyHit = |entHit;

  // locate same-register entry and a free slot
  always_comb begin
    sameFound = 1'b0;
    freeFound = 1'b0;
    samePtr = '0;
    freePtr = '0;
    for (int i = 0; i < Entries; i++) begin
      if (entRegMatch[i] && !sameFound) begin
        sameFound = 1'b1;
        samePtr = PtrW'(i);
      end
      if (!entValid[i] && !freeFound) begin
        freeFound = 1'b1;
        freePtr = PtrW'(i);
      end
    end
  end

  // reuse same-register slot, else free slot, else round-robin victim
  always_comb begin
    if (sameFound) begin
      target = samePtr;
    end else if (freeFound) begin
      target = freePtr;
    end else begin
      target = victim_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // allocation happens when the load returns, so a faulting speculative one is skipped
  logic pendAdv_q;
  logic pendSpec_q;

  // a deferred-fault speculative advanced load leaves no entry
  assign doAlloc = pipeDone && pendAdv_q && !(pendSpec_q && loadFault);

  always_comb begin
    entAlloc = '0;
    entKill = '0;
    if (isAdv) begin
      for (int i = 0; i < Entries; i++) begin
        if (entRegMatch[i]) begin
          entKill[i] = 1'b1;
        end
      end
    end
    if (doAlloc) begin
      entAlloc[target] = 1'b1;
    end
  end

  // round-robin replacement pointer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      victim_q <= sltt_pkg::ResetPtr;
    end else if (doAlloc && !freeFound && !sameFound) begin
      victim_q <= victim_q + PtrW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // load launch: advanced, control-speculative, or check-load miss
  assign start = reqValid && reqReady &&
                 ((req.op == sltt_pkg::OpAdvLoad) ||
                  (req.op == sltt_pkg::OpSpecAdvLoad) ||
                  (req.op == sltt_pkg::OpCtlSpecLoad) ||
                  ((req.op == sltt_pkg::OpCheckLoad) && !anyHit));

  load_pipe #(
    .Latency(sltt_pkg::LoadLatency)
  ) uPipe (
    .clk(clk),
    .nrst(nrst),
    .start(start),
    .dest(req.reg_),
    .busy(pipeBusy),
    .done(pipeDone),
    .doneReg(pipeReg)
  );

  // remember what the in-flight load was
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendAdv_q <= 1'b0;
      pendSpec_q <= 1'b0;
    end else if (start) begin
      pendAdv_q <= isAdv;
      pendSpec_q <= (req.op == sltt_pkg::OpSpecAdvLoad) ||
                    (req.op == sltt_pkg::OpCtlSpecLoad);
    end
  end

  // consumer of an in-flight destination waits for the data; a consumer
  // in the load's own group is illegal, so launch needs no stall term
  assign useStall = useValid && pipeBusy &&
                    (useReg == req.reg_ || useReg == pipeReg);

  assign memRd = start;
  assign memRdAddr = req.addr;

  ////////////////////////////////////////////////////////////////////////
  // stores pass straight through in program order; last write stands
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      memWr <= 1'b0;
      memWrAddr <= '0;
      memWrData <= '0;
    end else begin
      memWr <= storeValid;
      memWrAddr <= store.addr;
      memWrData <= storeData;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // writeback; faults on speculative loads become a deferred token
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wbValid <= 1'b0;
      wbReg <= '0;
      wbData <= '0;
      wbDeferred <= 1'b0;
    end else begin
      wbValid <= pipeDone;
      wbReg <= pipeReg;
      wbData <= memData;
      wbDeferred <= pipeDone && pendSpec_q && loadFault;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // check outcome and recovery redirect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      checkDone <= 1'b0;
      checkHit <= 1'b0;
      redirect <= 1'b0;
      redirectPc <= '0;
    end else begin
      checkDone <= isCheck;
      checkHit <= isCheck && anyHit;
      redirect <= isCheck && !anyHit &&
                  (req.op == sltt_pkg::OpCheckBranch);
      // sign-extended bundle offset added to the check's address
      redirectPc <= pc + {{(sltt_pkg::AddrW-sltt_pkg::OffW){req.offset[
                    sltt_pkg::OffW-1]}}, req.offset};
    end
  end
endmodule : speculative_load_tracking_table

//--- sltt_pkg.sv
// package for the speculative load tracking table
// assumes one core clock and active-low asynchronous reset
//
// What this block does
// - advanced load allocates a table entry
// - entry keyed by register, holds address, type, size
// - check searches for matching register and type
// - hit means no recovery, continue sequentially
// - check-branch miss redirects to recovery offset
// - check-load miss re-issues load, writes result
// - overlapping store invalidates the entry
// - new advanced load replaces same-register entry
// - entries may drop for capacity reasons
// - memory dependencies in group follow program order
// - later same-address store wins in memory
// - cache-hit load latency two cycles, consumers stall
// - control-speculative loads defer exceptions
// - check-branch carries register and branch offset
// - faulting speculative advanced load allocates nothing
// - full table evicts an entry by policy
package sltt_pkg;

  localparam int RegW = 7;
  localparam int AddrW = 64;
  localparam int DataW = 64;
  localparam int OffW = 21;
  localparam int SizeW = 4;
  localparam int LoadLatency = 2;
  localparam logic [1:0] ResetPtr = 2'h0;

  // kind of memory or check operation presented by the pipeline
  typedef enum logic [5:0] {
    OpNone = 6'h01,
    OpAdvLoad = 6'h02,
    OpSpecAdvLoad = 6'h04,
    OpCtlSpecLoad = 6'h08,
    OpCheckLoad = 6'h10,
    OpCheckBranch = 6'h20
  } op_e;

  typedef struct packed {
    op_e op;
    logic [RegW-1:0] reg_;
    logic isFloat;
    logic [AddrW-1:0] addr;
    logic [SizeW-1:0] size;
    logic [OffW-1:0] offset;
  } req_s;

  typedef struct packed {
    logic [AddrW-1:0] addr;
    logic [SizeW-1:0] size;
  } store_s;

endpackage : sltt_pkg

//--- sltt_entry.sv
// one table entry: storage, match on register/type, store-overlap kill
// assumes the parent serialises allocation and invalidation requests
`timescale 1ns/100ps
module sltt_entry (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control from the table
  input wire logic alloc,
  input wire logic kill,
  input wire sltt_pkg::req_s fill,
  // probes
  input wire logic [sltt_pkg::RegW-1:0] probeReg,
  input wire logic probeFloat,
  input wire sltt_pkg::store_s store,
  input wire logic storeValid,
  // results
  output logic valid,
  output logic regMatch,
  output logic hit
);
  logic valid_q;
  sltt_pkg::req_s ent_q;
  logic [sltt_pkg::AddrW:0] entEnd;
  logic [sltt_pkg::AddrW:0] stEnd;
  logic overlap;

  // byte ranges are half-open; extra bit avoids wrap at the top
  assign entEnd = {1'b0, ent_q.addr} + {{sltt_pkg::AddrW-3{1'b0}}, ent_q.size};
  assign stEnd = {1'b0, store.addr} + {{sltt_pkg::AddrW-3{1'b0}}, store.size};
  assign overlap = storeValid && ({1'b0, store.addr} < entEnd) &&
                   ({1'b0, ent_q.addr} < stEnd);

  assign valid = valid_q;
  assign regMatch = valid_q && (ent_q.reg_ == probeReg);
  assign hit = regMatch && (ent_q.isFloat == probeFloat);

  // alloc wins over a store kill in the same cycle: store is older
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      valid_q <= 1'b0;
    end else if (alloc) begin
      valid_q <= 1'b1;
    end else if (kill || overlap) begin
      valid_q <= 1'b0;
    end
  end

  // record register, type, address and size
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ent_q <= '0;
    end else if (alloc) begin
      ent_q <= fill;
    end
  end
endmodule : sltt_entry

//--- load_pipe.sv
// fixed-latency load return pipe with destination tag
// assumes memory answers cache hits in a fixed number of cycles
`timescale 1ns/100ps
module load_pipe #(
  parameter int Latency = sltt_pkg::LoadLatency
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // launch
  input wire logic start,
  input wire logic [sltt_pkg::RegW-1:0] dest,
  // completion
  output logic busy,
  output logic done,
  output logic [sltt_pkg::RegW-1:0] doneReg
);
  logic [Latency-1:0] stage_q;
  logic [sltt_pkg::RegW-1:0] reg_q;

  // shift a token so completion lands exactly Latency cycles later
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage_q <= '0;
      reg_q <= '0;
    end else begin
      stage_q <= {stage_q[Latency-2:0], start};
      if (start) begin
        reg_q <= dest;
      end
    end
  end

  // busy holds through the completion cycle; start stays out of it
  // because ready feeds back into start and would close a loop
  assign busy = |stage_q;
  assign done = stage_q[Latency-1];
  assign doneReg = reg_q;
endmodule : load_pipe

//--- mem_partner.sv
// memory model for cache-hit loads of the tracking table
// assumes the core clock and reset; answer sampled two edges after memRd
`timescale 1ns/100ps
module mem_partner (
  // core
  input wire logic clk,
  input wire logic nrst,
  // load request and fault control
  input wire logic memRd,
  input wire logic [sltt_pkg::AddrW-1:0] memRdAddr,
  input wire logic failNext,
  // answer
  output logic [sltt_pkg::DataW-1:0] memData,
  output logic loadFault
);
  logic [1:0] vq;
  logic [63:0] a1q;
  logic [63:0] a2q;

  function automatic logic [63:0] memVal(input logic [63:0] x);
    return {x[31:0] ^ 32'h5a5a5a5a, ~x[31:0]};
  endfunction : memVal

  // two-stage return pipe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vq <= 2'h0;
      a1q <= 64'h0;
      a2q <= 64'h0;
    end else begin
      vq <= {vq[0], memRd};
      a1q <= memRdAddr;
      a2q <= a1q;
    end
  end

  // data only true in the answer cycle, inverted otherwise
  assign memData = vq[1] ? memVal(a2q) : ~memVal(a2q);
  assign loadFault = vq[1] ? failNext : ~failNext;
endmodule : mem_partner

//--- sltt_chk.sv
// port-level checker for the speculative load tracking table
// assumes one clock domain, bound to the table's top module
`timescale 1ns/100ps
module sltt_chk (
  // core
  input wire logic clk,
  input wire logic nrst,
  // issue and stores
  input wire logic reqValid,
  input wire sltt_pkg::req_s req,
  input wire logic [sltt_pkg::AddrW-1:0] pc,
  input wire logic reqReady,
  input wire logic storeValid,
  input wire sltt_pkg::store_s store,
  input wire logic [sltt_pkg::DataW-1:0] storeData,
  // outputs
  input wire logic useStall,
  input wire logic memRd,
  input wire logic [sltt_pkg::AddrW-1:0] memRdAddr,
  input wire logic memWr,
  input wire logic [sltt_pkg::AddrW-1:0] memWrAddr,
  input wire logic [sltt_pkg::DataW-1:0] memWrData,
  input wire logic checkDone,
  input wire logic checkHit,
  input wire logic redirect,
  input wire logic [sltt_pkg::AddrW-1:0] redirectPc,
  input wire logic wbValid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic take;
  assign take = reqValid && reqReady;
  ////////////////////////////////////////////////////////////
  sequence s_launch; memRd; endsequence
  sequence s_refuse; !reqReady ##1 !reqReady; endsequence
  property p_refuse; s_launch |=> s_refuse; endproperty
  a_refuse: assert property (p_refuse) else $error("taken in flight");
  property p_wb; s_launch |-> ##3 wbValid; endproperty
  a_wb: assert property (p_wb) else $error("late writeback");
  property p_rdaddr; take && memRd |-> memRdAddr == req.addr; endproperty
  a_rdaddr: assert property (p_rdaddr) else $error("load addr");
  property p_chk;
    take && req.op inside {sltt_pkg::OpCheckLoad, sltt_pkg::OpCheckBranch}
      |=> checkDone;
  endproperty
  a_chk: assert property (p_chk) else $error("no check result");
  property p_redir; redirect |-> checkDone && !checkHit; endproperty
  a_redir: assert property (p_redir) else $error("bad redirect");
  property p_hit; checkDone && checkHit |-> !redirect; endproperty
  a_hit: assert property (p_hit) else $error("redirect on hit");
  property p_cl; take && req.op == sltt_pkg::OpCheckLoad |=> !redirect;
  endproperty
  a_cl: assert property (p_cl) else $error("check load redirect");
  property p_pc;
    take && req.op == sltt_pkg::OpCheckBranch |=> !redirect ||
      redirectPc == $past(pc) + 64'($signed($past(req.offset)));
  endproperty
  a_pc: assert property (p_pc) else $error("recovery address");
  property p_wr;
    storeValid |=> memWr && memWrAddr == $past(store.addr) &&
      memWrData == $past(storeData);
  endproperty
  a_wr: assert property (p_wr) else $error("store lost");
  property p_stall; useStall |-> !reqReady; endproperty
  a_stall: assert property (p_stall) else $error("stall idle");
endmodule : sltt_chk

bind speculative_load_tracking_table sltt_chk u_sltt_chk (.clk, .nrst,
  .reqValid, .req, .pc, .reqReady, .storeValid, .store, .storeData,
  .useStall, .memRd, .memRdAddr, .memWr, .memWrAddr, .memWrData,
  .checkDone, .checkHit, .redirect, .redirectPc, .wbValid);

//--- test_speculative_load_tracking_table.sv
// self-checking bench for the speculative load tracking table
// assumes mem_partner answers loads; inputs change on falling edges
`timescale 1ns/100ps
module test_speculative_load_tracking_table;
  logic clk, nrst, reqValid, storeValid, useValid, failNext;
  sltt_pkg::req_s req;
  sltt_pkg::store_s store;
  logic [63:0] pc, storeData, memData, memRdAddr, redirectPc, wbData, a, b;
  logic [6:0] useReg, wbReg, r;
  logic reqReady, loadFault, useStall, memRd, checkDone, checkHit;
  logic redirect, wbValid, wbDeferred, memWr;
  logic [63:0] memWrAddr, memWrData;
  logic [3:0] s, t;
  int failures, testsRun, seed, i;

  speculative_load_tracking_table #(.Entries(4))
    u_speculative_load_tracking_table (.clk, .nrst, .reqValid, .req, .pc,
    .reqReady, .loadFault, .memData, .storeValid, .store, .storeData,
    .useReg, .useValid, .useStall, .memRd, .memRdAddr, .memWr,
    .memWrAddr, .memWrData, .checkDone, .checkHit, .redirect,
    .redirectPc, .wbValid, .wbReg, .wbData, .wbDeferred);
  mem_partner u_mem_partner (.clk, .nrst, .memRd, .memRdAddr, .failNext,
    .memData, .loadFault);

  // core clock
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task chk(input logic [63:0] got, input logic [63:0] exp);
    testsRun++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task summarize;
    $display("failures %0d comparisons %0d", failures, testsRun);
    if (failures == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize

  function automatic logic ov(input logic [63:0] x, input logic [3:0] xs,
                              input logic [63:0] y, input logic [3:0] ys);
    return x < y + ys && y < x + xs;
  endfunction : ov

  // memory contents as the partner model serves them
  function automatic logic [63:0] memExp(input logic [63:0] x);
    return {x[31:0] ^ 32'h5a5a5a5a, ~x[31:0]};
  endfunction : memExp

  // request held until the edge that takes it
  task doOp(input sltt_pkg::op_e o, input logic [6:0] rg, input logic fl,
            input logic [63:0] ad, input logic [3:0] sz, input logic [20:0] f);
    int n;
    @(negedge clk);
    req = '{o, rg, fl, ad, sz, f};
    pc = {32'h0, $random(seed)};
    reqValid = 1;
    for (n = 0; n < 20 && !reqReady; n++) @(negedge clk);
    @(negedge clk);
    reqValid = 0;
  endtask : doOp

  task ld(input sltt_pkg::op_e o, input logic [6:0] rg,
          input logic [63:0] ad, input logic [3:0] sz);
    useReg = rg;
    useValid = 1;
    doOp(o, rg, 0, ad, sz, 21'h0);
    chk(useStall, 1);
    repeat (2) @(negedge clk);
    chk(wbValid, 1);
    chk(wbReg, rg);
    chk(wbDeferred, failNext);
    if (sz == 4'h8 && !failNext) chk(wbData, memExp(ad));
    chk(useStall, 0);
  endtask : ld

  // check op; a check-load miss waits for its reload
  task cb(input sltt_pkg::op_e o, input logic [6:0] rg, input logic fl,
          input logic [63:0] ad, input logic h);
    logic [20:0] f;
    int n;
    f = 21'($random(seed));
    doOp(o, rg, fl, ad, 4'h8, f);
    chk(checkDone, 1);
    chk(checkHit, h);
    chk(redirect, !h && o == sltt_pkg::OpCheckBranch);
    if (!h && o == sltt_pkg::OpCheckBranch)
      chk(redirectPc, pc + 64'($signed(f)));
    if (!h && o == sltt_pkg::OpCheckLoad) begin
      for (n = 0; n < 8 && wbValid !== 1'b1; n++) @(negedge clk);
      chk(wbValid, 1);
      chk(wbReg, rg);
      chk(wbData, memExp(ad));
    end
  endtask : cb

  task st(input logic [63:0] ad, input logic [3:0] sz);
    @(negedge clk);
    store = '{ad, sz};
    storeData = {$random(seed), $random(seed)};
    storeValid = 1;
    @(negedge clk);
    storeValid = 0;
    chk(memWr, 1);
    chk(memWrAddr, ad);
    chk(memWrData, storeData);
  endtask : st

  // hang guard, far beyond the expected run
  initial begin
    #200000;
    failures++;
    summarize();
  end

  // directed corners, then random load/store/check triples
  initial begin
    seed = 83024;
    {failures, testsRun} = '0;
    {nrst, reqValid, storeValid, useValid, failNext} = '0;
    {req, store, storeData, pc, useReg} = '0;
    req.op = sltt_pkg::OpNone;
    repeat (2) @(posedge clk);
    @(negedge clk) nrst = 1;
    ld(sltt_pkg::OpAdvLoad, 7'h05, 64'h1000, 4'h8);
    cb(sltt_pkg::OpCheckBranch, 7'h05, 1, 64'h0, 0);
    cb(sltt_pkg::OpCheckLoad, 7'h05, 0, 64'h1000, 1);
    st(64'h1008, 4'h4);
    cb(sltt_pkg::OpCheckBranch, 7'h05, 0, 64'h0, 1);
    st(64'h1007, 4'h1);
    cb(sltt_pkg::OpCheckBranch, 7'h05, 0, 64'h0, 0);
    ld(sltt_pkg::OpAdvLoad, 7'h06, 64'h2000, 4'h8);
    ld(sltt_pkg::OpAdvLoad, 7'h06, 64'h3000, 4'h8);
    st(64'h2000, 4'h8);
    cb(sltt_pkg::OpCheckBranch, 7'h06, 0, 64'h0, 1);
    st(64'h3004, 4'h2);
    cb(sltt_pkg::OpCheckLoad, 7'h06, 0, 64'h3000, 0);
    failNext = 1;
    ld(sltt_pkg::OpSpecAdvLoad, 7'h07, 64'h4000, 4'h8);
    ld(sltt_pkg::OpCtlSpecLoad, 7'h08, 64'h5000, 4'h8);
    failNext = 0;
    cb(sltt_pkg::OpCheckBranch, 7'h07, 0, 64'h0, 0);
    for (i = 0; i < 40; i++) begin
      r = 7'($random(seed));
      a = {47'h0, 1'b1, 16'($random(seed))};
      s = 4'h1 << ($random(seed) & 3);
      t = 4'h1 << ($random(seed) & 3);
      b = a + 64'($signed(5'($random(seed))));
      ld(sltt_pkg::OpAdvLoad, r, a, s);
      st(b, t);
      cb(sltt_pkg::OpCheckBranch, r, 0, 64'h0, !ov(a, s, b, t));
    end
    summarize();
  end
endmodule : test_speculative_load_tracking_table
